// >>> src/pio_defines.svh
// Constants of the parallel port set: addresses, reset values, pin masks.
// Assumes inclusion by the port modules and the testbench only.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses on the internal CPU bus
// ----------------------------------------------------------------------
`define PIO_P1_DDR_ADDR 16'hffb0
`define PIO_P2_DDR_ADDR 16'hffb1
`define PIO_P1_VAL_ADDR 16'hffb2
`define PIO_P2_VAL_ADDR 16'hffb3
`define PIO_P3_DDR_ADDR 16'hffb4
`define PIO_P4_DDR_ADDR 16'hffb5
`define PIO_P3_VAL_ADDR 16'hffb6
`define PIO_P4_VAL_ADDR 16'hffb7
`define PIO_P5_DDR_ADDR 16'hffb8
`define PIO_P6_DDR_ADDR 16'hffb9
`define PIO_P5_VAL_ADDR 16'hffba
`define PIO_P6_VAL_ADDR 16'hffbb
`define PIO_P8_DDR_ADDR 16'hffbd
`define PIO_P7_VAL_ADDR 16'hffbe
`define PIO_P8_VAL_ADDR 16'hffbf
`define PIO_P9_DDR_ADDR 16'hffc0
`define PIO_P9_VAL_ADDR 16'hffc1

// ----------------------------------------------------------------------
// Reset values and read values
// ----------------------------------------------------------------------
`define PIO_VAL_RESET 8'h00
`define PIO_DDR_RESET 8'h00
`define PIO_DDR_READ 8'hff
`define PIO_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------
// Implemented pins of each port
// ----------------------------------------------------------------------
`define PIO_MASK_FULL 8'hff
`define PIO_MASK_P5 8'h07
`define PIO_MASK_P8 8'h7f
`define PIO_NUM_PORTS 9
`define PIO_IDX_P7 4'h6
`define PIO_TRIG_BIT 70

`endif

// >>> src/pio_pkg.sv
// Types shared by the parallel port set.
// Assumes pio_defines.svh is on the include path.
package pio_pkg;

  // Operating modes; code 00 is not a legal strap and acts as single chip
  typedef enum logic [1:0] {
    PIO_MODE_EXP_NOROM = 2'b01,
    PIO_MODE_EXP_ROM = 2'b10,
    PIO_MODE_SINGLE = 2'b11
  } pio_mode_t;

  // Result of decoding a CPU bus address
  typedef struct packed {
    logic hit;
    logic is_ddr;
    logic [3:0] idx;
  } pio_dec_t;

endpackage : pio_pkg

// >>> src/pio_port.sv
// One parallel port: value latch, direction latch, pin synchroniser,
// pull-up control and the hand-over of pins to an auxiliary function.
// Assumes one clock domain; pin inputs are asynchronous to core_clk.
`timescale 1ns/1ps
`include "pio_defines.svh"

module pio_port
  import pio_pkg::*;
#(
  parameter logic [7:0] PIN_MASK = 8'hff,
  parameter bit HAS_DDR = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic val_we,
  input wire logic ddr_we,
  input wire logic ddr_lock,
  input wire logic [7:0] wdata,
  input wire logic force_all,
  input wire logic force_by_ddr,
  input wire logic [7:0] aux_own,
  input wire logic [7:0] aux_out,
  input wire logic [7:0] aux_oe,
  input wire logic hw_standby,
  input wire logic [7:0] pin_in,
  output logic [7:0] rd_value,
  output logic [7:0] pin_sync,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pullup_en
);
  logic [7:0] port_value_reg;
  logic [7:0] ddr_reg;
  logic [7:0] meta_reg;
  logic [7:0] ddr_eff;
  logic [7:0] own;

  // ----------------------------------------------------------------------
  // Latches written by the CPU
  // ----------------------------------------------------------------------

  // Output latch holds every value write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_value_reg <= `PIO_VAL_RESET;
    end else if (val_we) begin
      port_value_reg <= wdata & PIN_MASK;
    end
  end

  // Direction latch; absent on the input-only port, frozen when locked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ddr_reg <= `PIO_DDR_RESET;
    end else if (ddr_we && HAS_DDR && !ddr_lock) begin
      ddr_reg <= wdata & PIN_MASK;
    end
  end

  // Locked ports behave as all outputs; a 1 means output
  assign ddr_eff = HAS_DDR ? ((ddr_reg | {8{ddr_lock}}) & PIN_MASK)
                           : 8'h00;
  // Pins claimed by an auxiliary function
  assign own = (aux_own | {8{force_all}} | ({8{force_by_ddr}} & ddr_eff))
             & PIN_MASK;

  // ----------------------------------------------------------------------
  // Pin sampling and CPU read value
  // ----------------------------------------------------------------------

  // Two-stage synchroniser on the pin levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg & PIN_MASK;
    end
  end

  // Outputs read the latch, inputs read the pin level
  assign rd_value = (ddr_eff & port_value_reg)
                  | (~ddr_eff & pin_sync);

  // ----------------------------------------------------------------------
  // Pin drivers and pull-ups
  // ----------------------------------------------------------------------

  // Auxiliary owner drives in place of the latches; standby floats all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe_n <= 8'hff;
    end else begin
      pin_out <= ((own & aux_out) | (~own & port_value_reg))
                 & PIN_MASK;
      // The input-only port never drives, even for an auxiliary owner
      if (hw_standby || !HAS_DDR) begin
        pin_oe_n <= 8'hff;
      end else begin
        pin_oe_n <= ~(((own & aux_oe) | (~own & ddr_eff)) & PIN_MASK);
      end
    end
  end

  // Pull-up only for an unowned input whose latch holds 1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pullup_en <= 8'h00;
    end else if (hw_standby || !HAS_DDR) begin
      pullup_en <= 8'h00;
    end else begin
      pullup_en <= ~ddr_eff & port_value_reg & ~own & PIN_MASK;
    end
  end

endmodule : pio_port

// >>> src/pio_top.sv
// Set of nine parallel ports on the internal CPU bus.
// Assumes a single-cycle CPU bus on core_clk; pins asynchronous; the
// mode strap is stable while out of reset.
`timescale 1ns/1ps
`include "pio_defines.svh"

module pio_top
  import pio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire pio_mode_t mode,
  input wire logic hw_standby,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [71:0] aux_own,
  input wire logic [71:0] aux_out,
  input wire logic [71:0] aux_oe,
  output logic [71:0] aux_in,
  output logic converter_ext_trigger,
  input wire logic [71:0] pin_in,
  output logic [71:0] pin_out,
  output logic [71:0] pin_oe_n,
  output logic [71:0] pullup_en
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Maps a bus address to a port index and latch kind
  function automatic pio_dec_t addr_decode(input logic [15:0] a);
    pio_dec_t d;
    d = '{hit: 1'b1, is_ddr: 1'b0, idx: 4'h0};
    unique case (a)
      `PIO_P1_DDR_ADDR: d = '{1'b1, 1'b1, 4'h0};
      `PIO_P2_DDR_ADDR: d = '{1'b1, 1'b1, 4'h1};
      `PIO_P3_DDR_ADDR: d = '{1'b1, 1'b1, 4'h2};
      `PIO_P4_DDR_ADDR: d = '{1'b1, 1'b1, 4'h3};
      `PIO_P5_DDR_ADDR: d = '{1'b1, 1'b1, 4'h4};
      `PIO_P6_DDR_ADDR: d = '{1'b1, 1'b1, 4'h5};
      `PIO_P8_DDR_ADDR: d = '{1'b1, 1'b1, 4'h7};
      `PIO_P9_DDR_ADDR: d = '{1'b1, 1'b1, 4'h8};
      `PIO_P1_VAL_ADDR: d = '{1'b1, 1'b0, 4'h0};
      `PIO_P2_VAL_ADDR: d = '{1'b1, 1'b0, 4'h1};
      `PIO_P3_VAL_ADDR: d = '{1'b1, 1'b0, 4'h2};
      `PIO_P4_VAL_ADDR: d = '{1'b1, 1'b0, 4'h3};
      `PIO_P5_VAL_ADDR: d = '{1'b1, 1'b0, 4'h4};
      `PIO_P6_VAL_ADDR: d = '{1'b1, 1'b0, 4'h5};
      `PIO_P7_VAL_ADDR: d = '{1'b1, 1'b0, `PIO_IDX_P7};
      `PIO_P8_VAL_ADDR: d = '{1'b1, 1'b0, 4'h7};
      `PIO_P9_VAL_ADDR: d = '{1'b1, 1'b0, 4'h8};
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction : addr_decode

  // Implemented pins of a port by index
  function automatic logic [7:0] port_mask(input int idx);
    if (idx == 4) begin
      return `PIO_MASK_P5;
    end else if (idx == 7) begin
      return `PIO_MASK_P8;
    end else begin
      return `PIO_MASK_FULL;
    end
  endfunction : port_mask

  pio_dec_t wr_dec;
  pio_dec_t rd_dec;
  logic mode_exp_norom;
  logic mode_exp_rom;
  logic [7:0] port_rd [0:8];

  assign wr_dec = addr_decode(cpu_addr);
  assign rd_dec = addr_decode(cpu_addr);
  // Illegal strap code is treated as single chip
  assign mode_exp_norom = (mode == PIO_MODE_EXP_NOROM);
  assign mode_exp_rom = (mode == PIO_MODE_EXP_ROM);

  // ----------------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------------

  // Nine port slices; port N sits at index N-1
  generate
    for (genvar g = 0; g < `PIO_NUM_PORTS; g++) begin : g_port
      localparam logic [7:0] MASK = port_mask(g);
      localparam bit ADDR_PORT = (g == 0) || (g == 1);
      localparam bit BUS_PORT = (g == 2) || (g == 8);
      pio_port #(
        .PIN_MASK(MASK),
        .HAS_DDR(g != 6)
      ) u_port (
        .core_clk(core_clk),
        .rst(rst),
        .val_we(cpu_wr && wr_dec.hit && !wr_dec.is_ddr &&
                wr_dec.idx == 4'(g)),
        .ddr_we(cpu_wr && wr_dec.hit && wr_dec.is_ddr &&
                wr_dec.idx == 4'(g)),
        .ddr_lock(ADDR_PORT && mode_exp_norom),
        .wdata(cpu_wdata),
        .force_all((ADDR_PORT && mode_exp_norom) ||
                   (BUS_PORT && (mode_exp_norom || mode_exp_rom))),
        .force_by_ddr(ADDR_PORT && mode_exp_rom),
        .aux_own(aux_own[8*g +: 8]),
        .aux_out(aux_out[8*g +: 8]),
        .aux_oe(aux_oe[8*g +: 8]),
        .hw_standby(hw_standby),
        .pin_in(pin_in[8*g +: 8]),
        .rd_value(port_rd[g]),
        .pin_sync(aux_in[8*g +: 8]),
        .pin_out(pin_out[8*g +: 8]),
        .pin_oe_n(pin_oe_n[8*g +: 8]),
        .pullup_en(pullup_en[8*g +: 8])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // CPU read data and trigger
  // ----------------------------------------------------------------------

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      if (!rd_dec.hit) begin
        cpu_rdata <= `PIO_UNMAPPED_READ;
      end else if (rd_dec.is_ddr) begin
        cpu_rdata <= `PIO_DDR_READ;
      end else begin
        cpu_rdata <= port_rd[rd_dec.idx];
      end
    end
  end

  // Converter trigger taken from the synchronised port 9 pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      converter_ext_trigger <= 1'b0;
    end else begin
      converter_ext_trigger <= aux_in[`PIO_TRIG_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ddr_read_ones:
    assert property (cpu_rd && rd_dec.hit && rd_dec.is_ddr
                     |=> cpu_rdata == 8'hff)
    else $error("Direction latch read not all ones");

  a_p7_never_driven:
    assert property (pin_oe_n[55:48] == 8'hff && pullup_en[55:48] == 8'h00)
    else $error("Input-only port driven or pulled up");

  a_unused_pins_idle:
    assert property (pin_oe_n[39:35] == 5'h1f && pin_oe_n[63] &&
                     pullup_en[39:35] == 5'h00 && !pullup_en[63])
    else $error("Missing pin of narrow port active");

  a_standby_float:
    assert property (hw_standby |=> pin_oe_n == {72{1'b1}} &&
                     pullup_en == 72'h0)
    else $error("Standby did not float pins and drop pull-ups");

  a_value_to_pin:
    assert property (cpu_wr && cpu_addr == `PIO_P6_VAL_ADDR &&
                     aux_own[47:40] == 8'h00 ##1 aux_own[47:40] == 8'h00
                     |=> pin_out[47:40] == $past(cpu_wdata, 2))
    else $error("Value write did not reach port 6 pins");

  a_mode1_addr_own:
    assert property (mode == PIO_MODE_EXP_NOROM && !hw_standby
                     |=> pin_out[15:0] == $past(aux_out[15:0]) &&
                     pin_oe_n[15:0] == ~$past(aux_oe[15:0]))
    else $error("Address ports not owned in mode 1");

  a_bus_ports_own:
    assert property (mode == PIO_MODE_EXP_ROM
                     |=> pin_out[23:16] == $past(aux_out[23:16]) &&
                     pin_out[71:64] == $past(aux_out[71:64]))
    else $error("Bus ports not owned in expanded mode");

  a_input_read_pin:
    assert property (cpu_rd && cpu_addr == `PIO_P7_VAL_ADDR
                     |=> cpu_rdata == $past(aux_in[55:48]))
    else $error("Input port read not pin level");

  a_pullup_cause:
    assert property (pullup_en[31:24] != 8'h00 |->
                     $past(!hw_standby) &&
                     (pullup_en[31:24] & $past(aux_own[31:24])) == 8'h00)
    else $error("Pull-up on without cause");

  // Every bit written as zero must lose its pull-up two edges later
  a_value_zero_pullup:
    assert property (cpu_wr && cpu_addr == `PIO_P4_VAL_ADDR
                     |=> ##1
                     (pullup_en[31:24] & ~$past(cpu_wdata, 2)) == 8'h00)
    else $error("Zero write left pull-up on");

  c_value_write: cover property (cpu_wr && cpu_addr == `PIO_P4_VAL_ADDR);
  c_ddr_read: cover property (cpu_rd && cpu_addr == `PIO_P4_DDR_ADDR);
  c_pullup_on: cover property (pullup_en[31:24] != 8'h00);
  c_standby: cover property (hw_standby ##1 !hw_standby);

endmodule : pio_top

// >>> bench/pio_ext_model.sv
// Far side of the port pins: external circuits and the wire itself.
// Assumes pin_oe_n low means the port drives; tests never fight a port.
`timescale 1ns/1ps

module pio_ext_model (
  input wire logic core_clk,
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe_n,
  input wire logic [71:0] pullup_en,
  input wire logic [71:0] ext_drv,
  input wire logic [71:0] ext_en,
  output logic [71:0] pin_in
);
  logic [71:0] float_reg = '0;

  // A line nobody drives or pulls wanders: it shows the inverse level
  always_ff @(posedge core_clk) begin
    float_reg <= ~pin_in;
  end

  // Wire level: port drive, then outside drive, then pull-up
  always_comb begin
    for (int i = 0; i < 72; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_drv[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule : pio_ext_model

// >>> bench/testbench.sv
// Self-checking bench of the nine-port set, CPU byte accesses.
// Assumes pio_defines.svh on the include path and a 200 MHz core_clk.
`timescale 1ns/1ps
`include "pio_defines.svh"

module testbench;
  import pio_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  pio_mode_t mode = PIO_MODE_SINGLE;
  logic hw_standby = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic [7:0] rv;
  logic [71:0] aux_own = '0, aux_out = '0, aux_oe = '0, aux_in;
  logic [71:0] ext_drv = '0, ext_en = '0;
  logic [71:0] pin_in, pin_out, pin_oe_n, pullup_en;
  logic converter_ext_trigger;
  int fails = 0;
  int check_count = 0;

  // Clock, 5 ns period
  always #2.5 core_clk = ~core_clk;

  pio_top u_dut (.core_clk(core_clk), .rst(rst), .mode(mode),
    .hw_standby(hw_standby), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .aux_own(aux_own), .aux_out(aux_out), .aux_oe(aux_oe),
    .aux_in(aux_in), .converter_ext_trigger(converter_ext_trigger),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en));

  pio_ext_model u_ext (.core_clk(core_clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ext_drv(ext_drv),
    .ext_en(ext_en), .pin_in(pin_in));

  // ------------------------------------------------------------------
  // Access and checking tasks
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic do_reset(input pio_mode_t m);
    @(negedge core_clk);
    rst = 1'b1;
    mode = m;
    tick(4);
    rst = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge core_clk);
    cpu_wr = 1'b0;
  endtask : wr

  // Read strobe for one cycle, data taken after the sampling edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge core_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [71:0] seen,
                     input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog well beyond the ninety or so cycles of the tests
  initial begin
    #50000;
    fails++;
    stop_test();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset(PIO_MODE_SINGLE);
    chk("reset oe_n", pin_oe_n, {72{1'b1}});
    chk("reset pullup", pullup_en, '0);
    chk("reset rdata", cpu_rdata, '0);
    // Port 4: low nibble out, high nibble in, driven from outside
    ext_en[31:28] = 4'hf;
    ext_drv[31:28] = 4'h3;
    wr(`PIO_P4_DDR_ADDR, 8'h0f);
    wr(`PIO_P4_VAL_ADDR, 8'ha5);
    tick(3);
    chk("p4 out", pin_out[27:24], 4'h5);
    chk("p4 oe_n", pin_oe_n[31:24], 8'hf0);
    chk("p4 pullup", pullup_en[31:24], 8'ha0);
    rd(`PIO_P4_VAL_ADDR, rv);
    chk("p4 read", rv, 8'h35);
    rd(`PIO_P4_DDR_ADDR, rv);
    chk("ddr read", rv, `PIO_DDR_READ);
    wr(`PIO_P4_VAL_ADDR, 8'h05);
    tick(1);
    chk("pullup off by 0", pullup_en[31:24], 8'h00);
    ext_en[31:28] = 4'h0;
    wr(`PIO_P4_VAL_ADDR, 8'ha5);
    wr(`PIO_P4_DDR_ADDR, 8'hff);
    tick(1);
    chk("pullup off by ddr", pullup_en[31:24], 8'h00);
    chk("p4 all out", pin_out[31:24], 8'ha5);
    // Standby drops pull-ups and floats pins
    wr(`PIO_P4_DDR_ADDR, 8'h00);
    wr(`PIO_P4_VAL_ADDR, 8'hff);
    tick(1);
    chk("pullup on", pullup_en[31:24], 8'hff);
    hw_standby = 1'b1;
    tick(2);
    chk("stby pullup", pullup_en[31:24], 8'h00);
    chk("stby oe_n", pin_oe_n, {72{1'b1}});
    hw_standby = 1'b0;
    // Port widths: 3 and 7 bits
    wr(`PIO_P5_DDR_ADDR, 8'hff);
    wr(`PIO_P5_VAL_ADDR, 8'hff);
    wr(`PIO_P8_DDR_ADDR, 8'hff);
    wr(`PIO_P8_VAL_ADDR, 8'hff);
    tick(1);
    chk("p5 oe_n", pin_oe_n[39:32], 8'hf8);
    rd(`PIO_P5_VAL_ADDR, rv);
    chk("p5 read", rv, `PIO_MASK_P5);
    rd(`PIO_P8_VAL_ADDR, rv);
    chk("p8 read", rv, `PIO_MASK_P8);
    // Port 7: input only, no pull-ups, no direction latch
    ext_en[55:48] = 8'hff;
    ext_drv[55:48] = 8'h96;
    wr(`PIO_P7_VAL_ADDR, 8'hff);
    tick(3);
    rd(`PIO_P7_VAL_ADDR, rv);
    chk("p7 read", rv, 8'h96);
    chk("p7 aux_in", aux_in[55:48], 8'h96);
    chk("p7 pullup", pullup_en[55:48], 8'h00);
    rd(16'hffbc, rv);
    chk("unmapped read", rv, `PIO_UNMAPPED_READ);
    // Port 6 latch reaches its pin drive while still unowned
    wr(`PIO_P6_VAL_ADDR, 8'h3c);
    tick(1);
    chk("p6 latch out", pin_out[47:40], 8'h3c);
    // Port 6 and port 8 pin 0 handed to their auxiliary functions
    aux_own[47:40] = 8'hff;
    aux_oe[47:40] = 8'hff;
    aux_out[47:40] = 8'h5a;
    aux_own[56] = 1'b1;
    aux_oe[56] = 1'b1;
    aux_out[56] = 1'b0;
    tick(2);
    chk("aux out", pin_out[47:40], 8'h5a);
    chk("aux oe_n", pin_oe_n[47:40], 8'h00);
    chk("p8 aux", pin_out[56], 1'b0);
    // Converter trigger follows port 9 pin 6
    ext_en[70] = 1'b1;
    ext_drv[70] = 1'b1;
    tick(4);
    chk("trigger high", converter_ext_trigger, 1'b1);
    ext_drv[70] = 1'b0;
    tick(4);
    chk("trigger low", converter_ext_trigger, 1'b0);
    // Mode 1: ports 1, 2 carry address and port 3 data, automatically
    aux_out[23:0] = 24'h123456;
    aux_oe[23:0] = 24'hffffff;
    do_reset(PIO_MODE_EXP_NOROM);
    tick(2);
    chk("m1 bus out", pin_out[23:0], 24'h123456);
    chk("m1 bus oe_n", pin_oe_n[23:0], 24'h0);
    wr(`PIO_P1_DDR_ADDR, 8'h00);
    wr(`PIO_P1_VAL_ADDR, 8'h77);
    rd(`PIO_P1_VAL_ADDR, rv);
    chk("m1 p1 read", rv, 8'h77);
    // Mode 2: address pins chosen by direction bits
    do_reset(PIO_MODE_EXP_ROM);
    wr(`PIO_P2_DDR_ADDR, 8'h0f);
    tick(2);
    chk("m2 p2 oe_n", pin_oe_n[15:8], 8'hf0);
    chk("m2 p2 out", pin_out[11:8], 4'h4);
    stop_test();
  end
endmodule : testbench
